//--- smc_consts.svh
// Purpose: Named constants for the standby mode controller
// Assumes: Included by the package and the design module
// Notes: Mode request codes and reset source bit positions
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

// Requested mode codes
`define SMC_REQ_NONE 3'h0
`define SMC_REQ_HALT 3'h1
`define SMC_REQ_IDLE_MODE_ONE 3'h2
`define SMC_REQ_IDLE_MODE_TWO 3'h3
`define SMC_REQ_STOP 3'h4
`define SMC_REQ_SLEEP 3'h5
`define SMC_REQ_SWSTBY 3'h6

// Reset source bit positions
`define SMC_RST_PIN 0
`define SMC_RST_WDOG2 1
`define SMC_RST_LVD 2
`define SMC_RST_CLKMON 3
`define SMC_RST_POR 4
`define SMC_RST_VMON 5
`define SMC_RST_IWDOG 6
`define SMC_RST_W 7

`endif

//--- smc_pkg.sv
// Purpose: Types shared by the standby mode controller
// Assumes: Constants header is available
// Notes: Carrier structs and state encoding
`include "smc_consts.svh"

package smc_pkg;

    typedef enum logic [2:0] {
        SMC_RUN = 3'b000,
        SMC_HALT = 3'b001,
        SMC_IDLE_MODE_ONE = 3'b010,
        SMC_IDLE_MODE_TWO = 3'b011,
        SMC_STOP = 3'b100,
        SMC_SLEEP = 3'b101,
        SMC_SWSTBY = 3'b110
    } smc_state_t;

    // Wake sources presented to the block
    typedef struct packed {
        logic nmi;
        logic [7:0] irq;
        logic [7:0] irq_mask;
        logic [7:0] irq_standby_ok;
        logic [`SMC_RST_W-1:0] rst_src;
    } smc_wake_t;

    // Clock and circuit gates driven by the block
    typedef struct packed {
        logic cpu_clk_en;
        logic main_osc_en;
        logic pll_en;
        logic flash_en;
        logic periph_en;
        logic wdog_avail;
        logic sys_clk_sel_sub;
    } smc_gate_t;

    // Whole module state
    typedef struct packed {
        smc_state_t mode;
        logic pll_saved;
        logic pll_on;
        logic sub_run;
        logic woke;
        smc_gate_t gate;
    } smc_regs_t;

endpackage : smc_pkg

//--- smc_standby_ctrl.sv
// Purpose: Standby mode controller gating clocks and waking on events
// Assumes: All inputs synchronous to sys_clk
// Notes: One packed state struct, filled combinationally then registered
// How it works
// - Halt stops only the CPU clock
// - NMI or unmasked interrupt exits primary modes
// - Any listed reset source ends standby
// - Idle one keeps oscillator, PLL, flash
// - Idle two restores PLL state on exit, except when a reset source ends it (PLL then off)
// - Stop halts every internal circuit except the watchdog, which stays available
// - Subclock mode clocks whole system from subclock
// - Sleep mode makes ordinary watchdog unavailable
// - Sleep cancelled by any interrupt or reset
// - Software standby wakes on standby-capable interrupts
`timescale 1ns/1ps
`include "smc_consts.svh"

module smc_standby_ctrl (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Software requests
    input wire logic [2:0] mode_req,
    input wire logic mode_req_valid,
    input wire logic pll_on_req,
    input wire logic pll_off_req,
    input wire logic subclock_sel,
    // Wake sources
    input wire smc_pkg::smc_wake_t wake,
    // Gate outputs and status
    output smc_pkg::smc_gate_t gate,
    output smc_pkg::smc_state_t mode,
    output logic wake_pulse
);

    smc_pkg::smc_regs_t r;
    smc_pkg::smc_regs_t next_r;

    // Unmasked maskable interrupt pending
    function automatic logic smc_unmasked(input logic [7:0] irq, input logic [7:0] msk);
        smc_unmasked = |(irq & ~msk);
    endfunction : smc_unmasked

    // Gate pattern for a given mode
    function automatic smc_pkg::smc_gate_t smc_gates(input smc_pkg::smc_state_t m,
                                                     input logic pll, input logic sub);
        smc_pkg::smc_gate_t g;
        g.cpu_clk_en = 1'b1;
        g.main_osc_en = ~sub;
        g.pll_en = pll & ~sub;
        g.flash_en = 1'b1;
        g.periph_en = 1'b1;
        g.wdog_avail = 1'b1;
        g.sys_clk_sel_sub = sub;
        case (m)
            smc_pkg::SMC_HALT: begin
                g.cpu_clk_en = 1'b0;
            end
            smc_pkg::SMC_IDLE_MODE_ONE, smc_pkg::SMC_IDLE_MODE_TWO: begin
                g.cpu_clk_en = 1'b0;
                g.main_osc_en = ~sub;
                g.flash_en = 1'b1;
                g.periph_en = 1'b0;
            end
            smc_pkg::SMC_STOP: begin
                g.cpu_clk_en = 1'b0;
                g.main_osc_en = 1'b0;
                g.pll_en = 1'b0;
                g.flash_en = 1'b0;
                g.periph_en = 1'b0;
            end
            smc_pkg::SMC_SLEEP: begin
                g.cpu_clk_en = 1'b0;
                g.wdog_avail = 1'b0;
            end
            smc_pkg::SMC_SWSTBY: begin
                g.cpu_clk_en = 1'b0;
                g.main_osc_en = 1'b0;
                g.pll_en = 1'b0;
                g.flash_en = 1'b0;
                g.periph_en = 1'b0;
            end
            default: begin
                g.cpu_clk_en = 1'b1;
            end
        endcase
        smc_gates = g;
    endfunction : smc_gates

    logic any_rst;
    logic primary_wake;
    logic any_irq;
    logic standby_wake;

    // Wake qualification
    always_comb begin
        any_rst = |wake.rst_src;
        primary_wake = wake.nmi | smc_unmasked(wake.irq, wake.irq_mask);
        any_irq = wake.nmi | (|wake.irq);
        standby_wake = wake.nmi | (|(wake.irq & wake.irq_standby_ok));
    end

    // Next-state logic
    always_comb begin
        next_r = r;
        next_r.woke = 1'b0;
        next_r.sub_run = subclock_sel;
        if (r.mode == smc_pkg::SMC_RUN) begin
            // Software drives PLL normally only while running
            if (pll_on_req) begin
                next_r.pll_on = 1'b1;
            end else if (pll_off_req) begin
                next_r.pll_on = 1'b0;
            end
        end
        case (r.mode)
            smc_pkg::SMC_RUN: begin
                if (mode_req_valid && !any_rst) begin
                    case (mode_req)
                        `SMC_REQ_HALT: next_r.mode = smc_pkg::SMC_HALT;
                        `SMC_REQ_IDLE_MODE_ONE: next_r.mode = smc_pkg::SMC_IDLE_MODE_ONE;
                        `SMC_REQ_IDLE_MODE_TWO: begin
                            next_r.mode = smc_pkg::SMC_IDLE_MODE_TWO;
                            next_r.pll_saved = next_r.pll_on;
                            next_r.pll_on = 1'b0;
                        end
                        `SMC_REQ_STOP: next_r.mode = smc_pkg::SMC_STOP;
                        `SMC_REQ_SLEEP: next_r.mode = smc_pkg::SMC_SLEEP;
                        `SMC_REQ_SWSTBY: next_r.mode = smc_pkg::SMC_SWSTBY;
                        default: next_r.mode = smc_pkg::SMC_RUN;
                    endcase
                end
            end
            smc_pkg::SMC_HALT, smc_pkg::SMC_IDLE_MODE_ONE, smc_pkg::SMC_STOP: begin
                if (primary_wake || any_rst) begin
                    next_r.mode = smc_pkg::SMC_RUN;
                    next_r.woke = 1'b1;
                end
            end
            smc_pkg::SMC_IDLE_MODE_TWO: begin
                if (primary_wake || any_rst) begin
                    next_r.mode = smc_pkg::SMC_RUN;
                    next_r.pll_on = r.pll_saved;
                    next_r.woke = 1'b1;
                end
            end
            smc_pkg::SMC_SLEEP: begin
                if (any_irq || any_rst) begin
                    next_r.mode = smc_pkg::SMC_RUN;
                    next_r.woke = 1'b1;
                end
            end
            smc_pkg::SMC_SWSTBY: begin
                if (standby_wake || any_rst) begin
                    next_r.mode = smc_pkg::SMC_RUN;
                    next_r.woke = 1'b1;
                end
            end
            default: begin
                next_r.mode = smc_pkg::SMC_RUN;
            end
        endcase
        // Reset wins: clocking resumes, PLL falls back to off
        if (any_rst) begin
            next_r.pll_on = 1'b0;
        end
        next_r.gate = smc_gates(next_r.mode, next_r.pll_on, next_r.sub_run);
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r.mode <= smc_pkg::SMC_RUN;
            r.pll_saved <= 1'b0;
            r.pll_on <= 1'b0;
            r.sub_run <= 1'b0;
            r.woke <= 1'b0;
            r.gate <= '{cpu_clk_en: 1'b1, main_osc_en: 1'b1, pll_en: 1'b0,
                        flash_en: 1'b1, periph_en: 1'b1, wdog_avail: 1'b1,
                        sys_clk_sel_sub: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign gate = r.gate;
    assign mode = r.mode;
    assign wake_pulse = r.woke;

endmodule : smc_standby_ctrl

//--- smc_standby_ctrl_checker.sv
// Purpose: Port assertions for the standby controller
// Assumes: Bound to smc_standby_ctrl
// Notes: Reset exits are left out where PLL state is judged
`timescale 1ns/1ps
module smc_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Requests and wake sources
    input wire logic [2:0] mode_req,
    input wire logic mode_req_valid,
    input wire logic subclock_sel,
    input wire smc_pkg::smc_wake_t wake,
    // Watched outputs
    input wire smc_pkg::smc_gate_t gate,
    input wire smc_pkg::smc_state_t mode
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic pll_hold;
    wire rst_any = |wake.rst_src;
    // PLL level of the last run cycle
    always_ff @(posedge sys_clk) begin
        if (mode == smc_pkg::SMC_RUN)
            pll_hold <= gate.pll_en;
    end
    // Steps of an idle two exit and of an entry
    sequence s_idle_mode_two_exit;
        mode == smc_pkg::SMC_IDLE_MODE_TWO && !rst_any ##1 mode == smc_pkg::SMC_RUN;
    endsequence
    sequence s_request;
        mode == smc_pkg::SMC_RUN && mode_req_valid && !rst_any && mode_req inside {[1:6]};
    endsequence
    AST_HALT_CPU: assert property (mode == smc_pkg::SMC_HALT |-> !gate.cpu_clk_en && gate.main_osc_en)
        else $error("halt gating wrong");
    AST_NMI_EXIT: assert property (mode != smc_pkg::SMC_RUN && wake.nmi |=> mode == smc_pkg::SMC_RUN)
        else $error("nmi did not wake");
    AST_RST_EXIT: assert property (|wake.rst_src[3:0] |=> mode == smc_pkg::SMC_RUN)
        else $error("reset source did not end standby");
    AST_IDLE_MODE_ONE_KEEP: assert property (mode == smc_pkg::SMC_IDLE_MODE_ONE |-> gate.main_osc_en && gate.flash_en)
        else $error("idle one stopped oscillator or flash");
    AST_IDLE_MODE_TWO_PLL: assert property (s_idle_mode_two_exit |-> gate.pll_en == pll_hold)
        else $error("pll not restored");
    AST_STOP_ALL: assert property (mode == smc_pkg::SMC_STOP |-> !(gate.main_osc_en || gate.pll_en || gate.flash_en || gate.periph_en))
        else $error("stop left a circuit running");
    AST_SUB_SEL: assert property ((subclock_sel && mode == smc_pkg::SMC_RUN) [*2] |-> gate.sys_clk_sel_sub && !gate.main_osc_en)
        else $error("subclock not selected");
    AST_SLEEP_WDOG: assert property (mode == smc_pkg::SMC_SLEEP |-> !gate.wdog_avail && !gate.cpu_clk_en)
        else $error("watchdog available in sleep");
    AST_SLEEP_IRQ: assert property (mode == smc_pkg::SMC_SLEEP && |wake.irq |=> mode == smc_pkg::SMC_RUN)
        else $error("sleep ignored interrupt");
    AST_SWSTBY_HOLD: assert property (mode == smc_pkg::SMC_SWSTBY && !wake.nmi && !rst_any && !(|(wake.irq & wake.irq_standby_ok)) |=> mode == smc_pkg::SMC_SWSTBY)
        else $error("standby woke without cause");
    AST_ENTRY: assert property (s_request |=> mode == $past(mode_req))
        else $error("request not entered");
endmodule : smc_chk
bind smc_standby_ctrl smc_chk smc_chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .mode_req(mode_req),
    .mode_req_valid(mode_req_valid), .subclock_sel(subclock_sel), .wake(wake), .gate(gate), .mode(mode));

//--- smc_standby_ctrl_tb.sv
// Purpose: Self-checking bench for the standby controller
// Assumes: Checker is bound in its own file
// Notes: Wake exits are queued and judged by a monitor
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_standby_ctrl_tb;
    logic sys_clk, sys_rst, mode_req_valid, pll_on_req, pll_off_req, subclock_sel, wake_pulse;
    logic [2:0] mode_req, i;
    logic [31:0] seed = 32'hdacc5a7f;
    int failures, check_count, cyc;
    smc_pkg::smc_wake_t wake;
    smc_pkg::smc_gate_t gate;
    smc_pkg::smc_state_t mode;
    smc_pkg::smc_state_t exp_q[$];
    smc_standby_ctrl smc_standby_ctrl_i (.sys_clk, .sys_rst, .mode_req, .mode_req_valid,
        .pll_on_req, .pll_off_req, .subclock_sel, .wake, .gate, .mode, .wake_pulse);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    function automatic logic [2:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[2:0];
    endfunction : rnd
    task automatic check(input string n, input logic [2:0] s, input logic [2:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : step
    task automatic req(input logic [2:0] c);
        mode_req = c;
        mode_req_valid = 1'b1;
        step(1);
        mode_req_valid = 1'b0;
    endtask : req
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    // Monitor takes the oldest note on each wake pulse
    always @(posedge sys_clk) begin
        #1;
        if (wake_pulse === 1'b1)
            check("wake mode", mode, (exp_q.size() > 0) ? exp_q.pop_front() : 3'h7);
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        {mode_req, mode_req_valid, pll_on_req, pll_off_req, subclock_sel} = '0;
        wake = '0;
        sys_rst = 1'b1;
        step(20);
        sys_rst = 1'b0;
        pll_on_req = 1'b1;
        step(1);
        pll_on_req = 1'b0;
        check("pll on", gate.pll_en, 1'b1);
        // Every mode entered, then woken by a random interrupt
        for (int c = 1; c <= 6; c++) begin
            req(3'(c));
            check("mode", mode, 3'(c));
            check("cpu", gate.cpu_clk_en, 1'b0);
            if (c < 5) check("osc", gate.main_osc_en, c != 4);
            if (c < 5) check("flash", gate.flash_en, c != 4);
            if (c < 5) check("pll", gate.pll_en, c < 3);
            if (c >= 4) check("periph", gate.periph_en, c == 5);
            if (c == 5) check("wdog", gate.wdog_avail, 1'b0);
            i = rnd();
            wake.irq[i] = 1'b1;
            wake.irq_standby_ok[i] = 1'b1;
            exp_q.push_back(smc_pkg::SMC_RUN);
            step(1);
            wake = '0;
            if (c == 3) check("pll back", gate.pll_en, 1'b1);
            step(1);
        end
        $display("test modes done");
        // Masked interrupt holds halt, sleep ignores the mask
        wake.irq_mask = 8'hff;
        wake.irq = 8'h01 << rnd();
        req(`SMC_REQ_HALT);
        step(2);
        check("masked halt", mode, `SMC_REQ_HALT);
        wake.nmi = 1'b1;
        exp_q.push_back(smc_pkg::SMC_RUN);
        step(1);
        wake.nmi = 1'b0;
        req(`SMC_REQ_SLEEP);
        exp_q.push_back(smc_pkg::SMC_RUN);
        step(2);
        wake.irq_mask = 8'h00;
        req(`SMC_REQ_SWSTBY);
        step(2);
        check("standby hold", mode, `SMC_REQ_SWSTBY);
        wake = '0;
        wake.nmi = 1'b1;
        exp_q.push_back(smc_pkg::SMC_RUN);
        step(1);
        wake.nmi = 1'b0;
        $display("test masks done");
        // Each reset source ends stop while a halt request is presented
        for (int b = 0; b < 7; b++) begin
            req(`SMC_REQ_STOP);
            wake.rst_src[b] = 1'b1;
            exp_q.push_back(smc_pkg::SMC_RUN);
            req(`SMC_REQ_HALT);
            check("rst exit", mode, 3'h0);
            check("rst pll", gate.pll_en, 1'b0);
            wake = '0;
            step(1);
        end
        subclock_sel = 1'b1;
        step(2);
        check("sub", gate.sys_clk_sel_sub, 1'b1);
        subclock_sel = 1'b0;
        step(2);
        check("queue", 3'(exp_q.size()), 3'h0);
        $display("test resets done");
        end_of_test();
    end
endmodule : smc_standby_ctrl_tb
